// *** dv/host_model.sv ***
// host and playback engine model: register transfers and effect completion pulses
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic process_busy,
  input wire haptic_pkg::reg_rsp_s reg_rsp,
  output haptic_pkg::reg_req_s reg_req,
  output logic effect_done
);
  import haptic_pkg::*;
  logic [2:0] cnt;
  initial begin
    reg_req = '0;
    effect_done = 1'b0;
    cnt = 3'h0;
  end
  // eight cycles per effect so a sequence outlasts a trigger pulse pair
  always @(posedge sys_clk) begin
    cnt <= process_busy ? cnt + 3'h1 : 3'h0;
    effect_done <= process_busy && cnt == 3'h7;
  end
  // one-cycle request; the answer carries {ack, rdata} one edge later
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [8:0] q);
    @(posedge sys_clk);
    reg_req <= '{w, !w, a, d};
    @(posedge sys_clk);
    reg_req <= '0;
    #1;
    q = {reg_rsp.ack, reg_rsp.rdata};
  endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the haptic power state and fire control block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module tb;
  import haptic_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic chip_gate = 1'b0;
  logic trigger_input = 1'b0;
  logic out_short = 1'b0;
  logic reg_short = 1'b0;
  logic zero_cross = 1'b0;
  logic effect_done;
  logic fire_signal;
  logic process_busy;
  logic overcurrent_flag;
  reg_req_s reg_req;
  reg_rsp_s reg_rsp;
  drive_s drive;
  power_e power_state;
  logic [8:0] q;
  int n_fail = 0;
  int n_checks = 0;
  int n_done = 0;
  int n_abort = 0;
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    n_done += int'(effect_done);
    n_abort += int'(drive.abort);
  end
  haptic_power_state_and_fire_control #(.UNIT_CYC(4)) haptic_power_state_and_fire_control_inst (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .chip_gate(chip_gate),
    .trigger_input(trigger_input), .out_short(out_short), .reg_short(reg_short),
    .zero_cross(zero_cross), .effect_done(effect_done), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .drive(drive), .power_state(power_state), .fire_signal(fire_signal),
    .process_busy(process_busy), .overcurrent_flag(overcurrent_flag));
  host_model host_model_inst (.sys_clk(sys_clk), .process_busy(process_busy),
    .reg_rsp(reg_rsp), .reg_req(reg_req), .effect_done(effect_done));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.xfer(1'b1, a, d, q);
    `CHK("ack", 1'b1, q[8])
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    host_model_inst.xfer(1'b0, a, 8'h00, q);
    `CHK(nm, {1'b1, e}, q)
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && process_busy !== 1'b0; i++) tick(1);
  endtask
  task automatic pulse();
    @(posedge sys_clk) trigger_input <= 1'b1;
    repeat (2) @(posedge sys_clk);
    trigger_input <= 1'b0;
    tick(4);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  // ****
  // sequence
  // ****
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    chip_gate <= 1'b1;
    tick(3);
    rdc("ctrl", ADDR_CTRL, CTRL_RST);
    rdc("rated", ADDR_RATED, RATED_RST);
    rdc("clamp", ADDR_CLAMP, CLAMP_RST);
    rdc("hole", 8'h30, 8'h00);
    `CHK("pwr", PWR_HOLD, power_state)
    `CHK("lvl", RATED_RST, drive.level)
    wr(ADDR_LOOP, 8'h80);
    tick(2);
    `CHK("lvl", CLAMP_RST, drive.level)
    wr(ADDR_LOOP, 8'h00);
    wr(ADDR_SLOT0, 8'h33);
    @(posedge sys_clk) chip_gate <= 1'b0;
    tick(4);
    `CHK("pwr", PWR_SHUTDOWN, power_state)
    wr(ADDR_RATED, 8'h55);
    rdc("gated", ADDR_RATED, 8'h00);
    @(posedge sys_clk) chip_gate <= 1'b1;
    tick(3);
    rdc("kept", ADDR_SLOT0, 8'h33);
    rdc("dropped", ADDR_RATED, RATED_RST);
    for (int i = 0; i < 8; i++) wr(8'(ADDR_SLOT0 + i), (i < 3) ? 8'(i + 1) : 8'h00);
    wr(ADDR_CTRL, 8'h00);
    tick(2);
    `CHK("pwr", PWR_READY, power_state)
    n_done = 0;
    wr(ADDR_FIRE, 8'h01);
    `CHK("fsig", 1'b1, fire_signal)
    tick(2);
    `CHK("busy", 1'b1, process_busy)
    `CHK("pwr", PWR_ACTIVE, power_state)
    `CHK("eid", 8'h01, drive.effect_id)
    rdc("go", ADDR_FIRE, 8'h01);
    wait_idle();
    `CHK("ndone", 3, n_done)
    rdc("go", ADDR_FIRE, 8'h00);
    n_abort = 0;
    wr(ADDR_FIRE, 8'h01);
    tick(2);
    wr(ADDR_FIRE, 8'h00);
    tick(2);
    `CHK("busy", 1'b0, process_busy)
    `CHK("abort", 1, n_abort)
    wr(ADDR_FIRE, 8'h01);
    tick(2);
    wr(ADDR_CTRL, 8'h40);
    tick(1);
    `CHK("busy", 1'b0, process_busy)
    wr(ADDR_FIRE, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    @(posedge sys_clk) out_short <= 1'b1;
    tick(4);
    `CHK("oc", 1'b0, overcurrent_flag)
    wr(ADDR_FIRE, 8'h01);
    tick(4);
    `CHK("oc", 1'b1, overcurrent_flag)
    `CHK("cut", 1'b1, drive.cut_current)
    rdc("stat", ADDR_STATUS, 8'h03);
    @(posedge sys_clk) out_short <= 1'b0;
    tick(4);
    `CHK("oc", 1'b0, overcurrent_flag)
    wr(ADDR_FIRE, 8'h00);
    wr(ADDR_FIRE, 8'h01);
    tick(2);
    `CHK("busy", 1'b0, process_busy)
    wr(ADDR_FIRE, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_FIRE, 8'h01);
    tick(2);
    `CHK("busy", 1'b1, process_busy)
    wait_idle();
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CTRL, 8'(m));
      `CHK("fsig", (m inside {3, 4, 5}), fire_signal)
      rdc("go", ADDR_FIRE, 8'h00);
    end
    wr(ADDR_CTRL, 8'h02);
    @(posedge sys_clk) trigger_input <= 1'b1;
    tick(4);
    rdc("lvl", ADDR_FIRE, 8'h01);
    @(posedge sys_clk) trigger_input <= 1'b0;
    tick(4);
    rdc("lvl", ADDR_FIRE, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    pulse();
    rdc("edge", ADDR_FIRE, 8'h01);
    `CHK("busy", 1'b1, process_busy)
    pulse();
    rdc("edge", ADDR_FIRE, 8'h00);
    `CHK("busy", 1'b0, process_busy)
    // one-unit drive, drain and blank so the sense window is reached quickly
    wr(ADDR_DRIVE, 8'h00);
    wr(ADDR_SENSE, 8'h00);
    wr(ADDR_CTRL, 8'h05);
    tick(1);
    `CHK("drv", 1'b1, drive.drive_on)
    tick(4);
    `CHK("drain", 1'b0, drive.drive_on)
    `CHK("hiz", 1'b0, drive.hi_z)
    tick(8);
    `CHK("hiz", 1'b1, drive.hi_z)
    `CHK("adc", 1'b1, drive.adc_convert)
    @(posedge sys_clk) zero_cross <= 1'b1;
    tick(3);
    `CHK("zc", 1'b1, drive.drive_on)
    `CHK("adc", 1'b0, drive.adc_convert)
    @(posedge sys_clk) zero_cross <= 1'b0;
    wr(ADDR_SLOT0, 8'h77);
    wr(ADDR_CTRL, 8'h80);
    tick(2);
    rdc("srst", ADDR_CTRL, CTRL_RST);
    rdc("srst", ADDR_SLOT0, SLOT_RST);
    wr(ADDR_SLOT0, 8'h77);
    @(posedge sys_clk) reg_short <= 1'b1;
    tick(4);
    `CHK("pwr", PWR_SHUTDOWN, power_state)
    @(posedge sys_clk) reg_short <= 1'b0;
    tick(4);
    rdc("regs", ADDR_SLOT0, SLOT_RST);
    end_of_test();
  end
endmodule

// *** logic/haptic_power_state_and_fire_control.sv ***
// power state, mode decode, fire request, sequencer and back-emf timing for the haptic driver
// Function
// - gate pin high means active; low means shutdown with registers kept
// - gate low still acknowledges bus requests but performs no read or write
// - soft power-cycle bit aborts playback, restores defaults, then clears itself
// - low-power hold bit is set after reset; registers and access stay available
// - setting the hold bit stops any playing waveform at once
// - host clears the hold bit to reach ready and allow processes
// - processes start only from the internal fire request, not the fire bit
// - after a short, playback resumes only once the host changes mode
// - decode 3-bit mode; value 3 split by pulse-or-analog select bit
// - host writes one to the fire register to start internal-trigger playback
// - fire bit stays set until the whole sequence finishes, then self-clears
// - host clearing the fire bit during playback cancels the sequence
// - firing plays waveform ids from the eight slots, or runs calibration/diagnostics
// - in external trigger modes the fire bit reflects the trigger input
// - continuous modes assert fire request without touching the fire bit
// - output short during playback sets overcurrent flag until gone and cuts current
// - output shorts are checked only while a process runs
// - regulator short shuts down, then restarts with default settings
// - drive-time seeds resonance half-period for linear; sample rate for rotating
// - wait drain time, then blanking, then sense honouring minimum detect time
// - closed loop uses rated level; open loop uses the overdrive limit
// - edge mode: rising edge sets fire bit, second rising edge cancels and clears
// - level mode: fire bit follows trigger input; falling edge cancels
`timescale 1ns/1ps
module haptic_power_state_and_fire_control #(
  parameter int unsigned UNIT_CYC = haptic_pkg::TIME_UNIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic chip_gate,
  input wire logic trigger_input,
  input wire logic out_short,
  input wire logic reg_short,
  input wire logic zero_cross,
  input wire logic effect_done,
  input wire haptic_pkg::reg_req_s reg_req,
  output haptic_pkg::reg_rsp_s reg_rsp,
  output haptic_pkg::drive_s drive,
  output haptic_pkg::power_e power_state,
  output logic fire_signal,
  output logic process_busy,
  output logic overcurrent_flag
);
  import haptic_pkg::*;

  localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYC - 1);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic gate_m;
    logic gate_s;
    logic trig_m;
    logic trig_s;
    logic trig_d;
    logic osh_m;
    logic osh_s;
    logic rsh_m;
    logic rsh_s;
    logic zc_m;
    logic zc_s;
    logic [7:0] ctrl;
    logic [7:0][7:0] slots;
    logic go;
    logic [7:0] rated;
    logic [7:0] clamp;
    logic [4:0] drive_time;
    logic [3:0] drain;
    logic [3:0] blank;
    logic [7:0] loop_cfg;
    logic oc_flag;
    logic short_lock;
    logic busy;
    logic fired;
    logic [2:0] slot_idx;
    phase_e phase;
    logic [15:0] unit_cnt;
    logic [4:0] phase_cnt;
    logic [4:0] half_est;
    logic ack;
    logic [7:0] rdata;
    logic abort;
    logic [7:0] level;
    logic [7:0] effect_id;
    power_e pwr;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // register contents after power-up, soft power cycle or regulator fault
  function automatic st_s reg_defaults(input st_s x);
    st_s y;
    y = x;
    y.ctrl = CTRL_RST;
    y.slots = {8{SLOT_RST}};
    y.go = 1'b0;
    y.rated = RATED_RST;
    y.clamp = CLAMP_RST;
    y.drive_time = DRIVE_RST;
    y.drain = DISS_RST;
    y.blank = BLANK_RST;
    y.loop_cfg = LOOP_RST;
    y.oc_flag = 1'b0;
    y.short_lock = 1'b0;
    y.busy = 1'b0;
    y.fired = 1'b0;
    y.slot_idx = 3'h0;
    y.phase = PH_IDLE;
    y.unit_cnt = 16'h0000;
    y.phase_cnt = 5'h00;
    y.half_est = DRIVE_RST;
    return y;
  endfunction

  function automatic st_s init_state();
    st_s y;
    y = '0;
    y = reg_defaults(y);
    y.pwr = PWR_SHUTDOWN;
    return y;
  endfunction

  function automatic logic [7:0] read_mux(input st_s x, input logic [7:0] addr);
    logic [7:0] off;
    off = addr - ADDR_SLOT0;
    if (addr >= ADDR_SLOT0 && addr <= ADDR_SLOT7) begin
      return x.slots[off[2:0]];
    end
    unique case (addr)
      ADDR_STATUS: return {6'h00, x.short_lock, x.oc_flag};
      ADDR_CTRL: return x.ctrl;
      ADDR_FIRE: return {7'h00, x.go};
      ADDR_RATED: return x.rated;
      ADDR_CLAMP: return x.clamp;
      ADDR_DRIVE: return {3'h0, x.drive_time};
      ADDR_SENSE: return {x.drain, x.blank};
      ADDR_LOOP: return x.loop_cfg;
      default: return 8'h00;
    endcase
  endfunction

  // ************************************************
  // decode
  // ************************************************
  mode_e mode;
  logic continuous;
  logic able;
  logic trig_rise;
  logic seq_last;
  logic analog_in;
  logic [7:0] slot_off;

  always_comb begin
    mode = mode_e'(st_ff.ctrl[2:0]);
    // value 3 splits into pulse or analog input; both are continuous here
    analog_in = (mode == MODE_PWM_ANALOG) && st_ff.loop_cfg[LOOP_ANALOG_BIT];
    continuous = (mode == MODE_PWM_ANALOG) || (mode == MODE_AUDIO) ||
                 (mode == MODE_REAL_TIME_PLAYBACK);
    fire_signal = st_ff.go | continuous;
    able = st_ff.gate_s & ~st_ff.ctrl[CTRL_HOLD_BIT] & ~st_ff.short_lock;
    trig_rise = st_ff.trig_s & ~st_ff.trig_d;
    seq_last = (st_ff.slot_idx == 3'h7) || (st_ff.slots[st_ff.slot_idx + 3'h1] == 8'h00);
    slot_off = reg_req.addr - ADDR_SLOT0;
  end

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    nxt_st = st_ff;
    // pins and analog flags are asynchronous: two flops before use
    nxt_st.gate_m = chip_gate;
    nxt_st.gate_s = st_ff.gate_m;
    nxt_st.trig_m = trigger_input;
    nxt_st.trig_s = st_ff.trig_m;
    nxt_st.trig_d = st_ff.trig_s;
    nxt_st.osh_m = out_short;
    nxt_st.osh_s = st_ff.osh_m;
    nxt_st.rsh_m = reg_short;
    nxt_st.rsh_s = st_ff.rsh_m;
    nxt_st.zc_m = zero_cross;
    nxt_st.zc_s = st_ff.zc_m;
    nxt_st.abort = 1'b0;
    nxt_st.ack = reg_req.wr | reg_req.rd;
    if (reg_req.rd && st_ff.gate_s) begin
      nxt_st.rdata = read_mux(st_ff, reg_req.addr);
    end else if (reg_req.rd) begin
      nxt_st.rdata = 8'h00;
    end
    if (st_ff.rsh_s || st_ff.ctrl[CTRL_SRST_BIT]) begin
      // whole register set returns to defaults, which also drops the reset bit
      nxt_st = reg_defaults(nxt_st);
      nxt_st.abort = st_ff.busy;
    end else begin
      // process control runs first so a host set in the same cycle wins
      if (~fire_signal) begin
        nxt_st.fired = 1'b0;
      end
      if (~st_ff.osh_s) begin
        nxt_st.oc_flag = 1'b0;
      end
      if (st_ff.busy) begin
        if (st_ff.osh_s) begin
          nxt_st.oc_flag = 1'b1;
          nxt_st.short_lock = 1'b1;
        end
        if (~fire_signal || ~able || st_ff.osh_s) begin
          nxt_st.busy = 1'b0;
          nxt_st.abort = 1'b1;
          nxt_st.phase = PH_IDLE;
        end else if (effect_done && !continuous) begin
          if (mode == MODE_DIAG || mode == MODE_CALIB || seq_last) begin
            nxt_st.busy = 1'b0;
            nxt_st.go = 1'b0;
            nxt_st.phase = PH_IDLE;
          end else begin
            nxt_st.slot_idx = st_ff.slot_idx + 3'h1;
          end
        end
      end else if (fire_signal && !st_ff.fired && able) begin
        nxt_st.busy = 1'b1;
        nxt_st.fired = 1'b1;
        nxt_st.slot_idx = 3'h0;
        nxt_st.half_est = st_ff.drive_time;
        nxt_st.phase = PH_DRIVE;
        nxt_st.unit_cnt = 16'h0000;
        nxt_st.phase_cnt = 5'h00;
      end
      // host writes
      if (reg_req.wr && st_ff.gate_s) begin
        if (reg_req.addr >= ADDR_SLOT0 && reg_req.addr <= ADDR_SLOT7) begin
          nxt_st.slots[slot_off[2:0]] = reg_req.wdata;
        end
        unique case (reg_req.addr)
          ADDR_CTRL: begin
            nxt_st.ctrl = reg_req.wdata;
            if (reg_req.wdata[2:0] != st_ff.ctrl[2:0] && !(st_ff.busy && st_ff.osh_s)) begin
              nxt_st.short_lock = 1'b0;
            end
          end
          ADDR_FIRE: begin
            if (mode != MODE_LEVEL_TRIG) begin
              nxt_st.go = reg_req.wdata[FIRE_BIT];
            end
          end
          ADDR_RATED: nxt_st.rated = reg_req.wdata;
          ADDR_CLAMP: nxt_st.clamp = reg_req.wdata;
          ADDR_DRIVE: nxt_st.drive_time = reg_req.wdata[4:0];
          ADDR_SENSE: begin
            nxt_st.drain = reg_req.wdata[7:4];
            nxt_st.blank = reg_req.wdata[3:0];
          end
          ADDR_LOOP: nxt_st.loop_cfg = reg_req.wdata;
          default: begin
          end
        endcase
      end
      // external trigger owns the fire bit in its modes
      if (mode == MODE_EDGE_TRIG && trig_rise) begin
        nxt_st.go = ~st_ff.go;
      end else if (mode == MODE_LEVEL_TRIG) begin
        nxt_st.go = st_ff.trig_s;
      end
      // back-emf timing: drive, drain, blank, then sense
      if (st_ff.busy && nxt_st.busy) begin
        if (st_ff.unit_cnt >= UNIT_LAST) begin
          nxt_st.unit_cnt = 16'h0000;
          nxt_st.phase_cnt = st_ff.phase_cnt + 5'h01;
          unique case (st_ff.phase)
            PH_DRIVE: begin
              if (st_ff.phase_cnt >= st_ff.half_est) begin
                nxt_st.phase = PH_DRAIN;
                nxt_st.phase_cnt = 5'h00;
              end
            end
            PH_DRAIN: begin
              if (st_ff.phase_cnt >= {1'b0, st_ff.drain}) begin
                nxt_st.phase = PH_BLANK;
                nxt_st.phase_cnt = 5'h00;
              end
            end
            PH_BLANK: begin
              if (st_ff.phase_cnt >= {1'b0, st_ff.blank}) begin
                nxt_st.phase = PH_SENSE;
                nxt_st.phase_cnt = 5'h00;
              end
            end
            PH_SENSE: begin
              if (st_ff.phase_cnt >= SENSE_MAX_UNITS) begin
                // no crossing seen: the half-period guess was too short
                nxt_st.phase = PH_DRIVE;
                nxt_st.phase_cnt = 5'h00;
                if (st_ff.loop_cfg[LOOP_LRA_BIT] && st_ff.half_est != 5'h1f) begin
                  nxt_st.half_est = st_ff.half_est + 5'h01;
                end
              end
            end
            PH_IDLE: begin
            end
          endcase
        end else begin
          nxt_st.unit_cnt = st_ff.unit_cnt + 16'h0001;
        end
        // crossings earlier than the minimum detect time are ignored
        if (st_ff.phase == PH_SENSE && st_ff.zc_s &&
            st_ff.phase_cnt >= {3'h0, st_ff.loop_cfg[1:0]}) begin
          nxt_st.phase = PH_DRIVE;
          nxt_st.phase_cnt = 5'h00;
          nxt_st.unit_cnt = 16'h0000;
          if (st_ff.loop_cfg[LOOP_LRA_BIT] && st_ff.phase_cnt == {3'h0, st_ff.loop_cfg[1:0]} &&
              st_ff.half_est != 5'h01) begin
            nxt_st.half_est = st_ff.half_est - 5'h01;
          end
        end
      end
    end
    // outputs held in flops
    nxt_st.level = st_ff.loop_cfg[LOOP_OPEN_BIT] ? st_ff.clamp : st_ff.rated;
    nxt_st.effect_id = (mode == MODE_DIAG || mode == MODE_CALIB || continuous) ? 8'h00 :
                       st_ff.slots[st_ff.slot_idx];
    if (st_ff.rsh_s || !st_ff.gate_s) begin
      nxt_st.pwr = PWR_SHUTDOWN;
    end else if (st_ff.ctrl[CTRL_HOLD_BIT]) begin
      nxt_st.pwr = PWR_HOLD;
    end else if (st_ff.busy) begin
      nxt_st.pwr = PWR_ACTIVE;
    end else begin
      nxt_st.pwr = PWR_READY;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= init_state();
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  always_comb begin
    reg_rsp.ack = st_ff.ack;
    reg_rsp.rdata = st_ff.rdata;
    drive.drive_on = st_ff.phase[1];
    drive.hi_z = st_ff.phase[3] | st_ff.phase[4];
    drive.adc_convert = st_ff.phase[4];
    drive.level = st_ff.level;
    drive.effect_id = st_ff.effect_id;
    drive.cut_current = st_ff.oc_flag;
    drive.abort = st_ff.abort;
    power_state = st_ff.pwr;
    process_busy = st_ff.busy;
    overcurrent_flag = st_ff.oc_flag;
  end

  // ************************************************
  // assertions
  // ************************************************
  a_gate_no_write: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && reg_req.wr && !st_ff.gate_s && reg_req.addr == ADDR_RATED && !st_ff.rsh_s &&
    !st_ff.ctrl[CTRL_SRST_BIT] |=> st_ff.rated == $past(st_ff.rated))
    else $error("register written while gate low");
  a_ack_always: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && (reg_req.wr || reg_req.rd) |=> reg_rsp.ack)
    else $error("bus request not acknowledged");
  a_srst_defaults: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && st_ff.ctrl[CTRL_SRST_BIT] |=> st_ff.ctrl == CTRL_RST && st_ff.rated == RATED_RST
    && !st_ff.busy)
    else $error("soft power cycle did not restore defaults");
  a_hold_stops: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && st_ff.busy && st_ff.ctrl[CTRL_HOLD_BIT] |=> !st_ff.busy && drive.abort)
    else $error("hold did not stop playback");
  a_gate_shutdown: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !st_ff.gate_s |=> power_state == PWR_SHUTDOWN)
    else $error("gate low without shutdown");
  a_cont_keeps_go: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && continuous && !st_ff.go && !reg_req.wr && !st_ff.busy |=> !st_ff.go && fire_signal)
    else $error("continuous mode touched fire bit");
  a_level_follow: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && mode == MODE_LEVEL_TRIG && !st_ff.rsh_s && !st_ff.ctrl[CTRL_SRST_BIT]
    |=> st_ff.go == $past(st_ff.trig_s))
    else $error("fire bit not following trigger");
  a_oc_only_busy: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !st_ff.oc_flag && !st_ff.busy |=> !overcurrent_flag)
    else $error("short flagged while idle");
  a_done_clears_go: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && st_ff.busy && fire_signal && able && !st_ff.osh_s && effect_done && seq_last &&
    mode == MODE_INT_TRIG && !reg_req.wr && !st_ff.rsh_s && !st_ff.ctrl[CTRL_SRST_BIT]
    |=> !st_ff.go && !st_ff.busy)
    else $error("fire bit not cleared after sequence");

endmodule

// *** pkg/haptic_pkg.sv ***
// shared constants, encodings and carrier structs for the haptic power and fire control block
package haptic_pkg;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 8;
  // one unit of the drive, dissipation, blanking and detect fields
  localparam int TIME_UNIT_NS = 50000;
  localparam int TIME_UNIT_CYC = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest sense window before the estimate is stretched
  localparam logic [4:0] SENSE_MAX_UNITS = 5'h0f;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_SLOT0 = 8'h04;
  localparam logic [7:0] ADDR_SLOT7 = 8'h0b;
  localparam logic [7:0] ADDR_FIRE = 8'h0c;
  localparam logic [7:0] ADDR_RATED = 8'h16;
  localparam logic [7:0] ADDR_CLAMP = 8'h17;
  localparam logic [7:0] ADDR_DRIVE = 8'h1a;
  localparam logic [7:0] ADDR_SENSE = 8'h1b;
  localparam logic [7:0] ADDR_LOOP = 8'h1c;

  // ************************************************
  // field positions
  // ************************************************
  localparam int CTRL_SRST_BIT = 7;
  localparam int CTRL_HOLD_BIT = 6;
  localparam int FIRE_BIT = 0;
  localparam int LOOP_OPEN_BIT = 7;
  localparam int LOOP_LRA_BIT = 6;
  localparam int LOOP_ANALOG_BIT = 5;
  localparam int STAT_OC_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;

  // ************************************************
  // values after reset
  // ************************************************
  localparam logic [7:0] CTRL_RST = 8'h40;
  localparam logic [7:0] SLOT_RST = 8'h00;
  localparam logic [7:0] RATED_RST = 8'h3e;
  localparam logic [7:0] CLAMP_RST = 8'h8c;
  localparam logic [4:0] DRIVE_RST = 5'h13;
  localparam logic [3:0] DISS_RST = 4'h1;
  localparam logic [3:0] BLANK_RST = 4'h1;
  localparam logic [7:0] LOOP_RST = 8'h00;

  // ************************************************
  // encodings
  // ************************************************
  typedef enum logic [2:0] {
    MODE_INT_TRIG = 3'h0,
    MODE_EDGE_TRIG = 3'h1,
    MODE_LEVEL_TRIG = 3'h2,
    MODE_PWM_ANALOG = 3'h3,
    MODE_AUDIO = 3'h4,
    MODE_REAL_TIME_PLAYBACK = 3'h5,
    MODE_DIAG = 3'h6,
    MODE_CALIB = 3'h7
  } mode_e;

  typedef enum logic [3:0] {
    PWR_SHUTDOWN = 4'b0001,
    PWR_HOLD = 4'b0010,
    PWR_READY = 4'b0100,
    PWR_ACTIVE = 4'b1000
  } power_e;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_DRIVE = 5'b00010,
    PH_DRAIN = 5'b00100,
    PH_BLANK = 5'b01000,
    PH_SENSE = 5'b10000
  } phase_e;

  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } reg_rsp_s;

  typedef struct packed {
    logic drive_on;
    logic hi_z;
    logic adc_convert;
    logic [7:0] level;
    logic [7:0] effect_id;
    logic cut_current;
    logic abort;
  } drive_s;

endpackage
